// ### scc_regs.sv
// scc_regs: interrupt enable/pending, abort/reset, bus control, capability registers
// host side runs on sdClk; registers live on mclk; local processor on mclk
// Functional notes
// - function 1 interrupt reaches host only with its enable and master enable set.
// - master enable bit 0, host read/write, resets 0; while 0 no interrupts.
// - pending register bit 1 reads function 1 pending state, host read-only.
// - card reset bit 3 write-only; writing 1 resets functions, then self-clears.
// - abort select bits 2..0 host write-only, reset zero, name aborted function.
// - bit 7 host read/write, reset 0; 1 disconnects data line 3 pull-up.
// - continuous SPI interrupt support bit 6 locally writable, host read-only, resets 1.
// - continuous SPI interrupt enable bit 5 host read/write, resets 0.
// - bus width bits 1..0 host read/write, local read-only; 0 one-bit, 2 four-bit.
// - capability bits 7 and 6 locally writable, host read-only, reset 0.
// - inter-block interrupt control bit 5 writable both sides, resets 1, gates those interrupts.
// - inter-block interrupt support bit 4 locally writable, host read-only, resets 1.
// - suspend/resume support bit 3 locally writable, host readable, resets 1.
// - read-wait support bit 2 locally writable, host read-only, resets 1.
// - multiblock support bit 1 locally writable, host read-only, resets 1.
// - direct-command support bit 0 locally writable, host read-only, resets 1.
// - registers decoded only in function 0 address space.
`default_nettype none
module scc_regs (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sdClk,
   input wire logic hostReqValid,
   input wire scc_pkg::scc_req_type hostReq,
   output logic hostBusy,
   output logic hostDone,
   output logic [7:0] hostRdData,
   output logic irqToHost,
   input wire logic locWrEn,
   input wire logic [16:0] locAddr,
   input wire logic [7:0] locWrData,
   output logic [7:0] locRdData,
   input wire logic func1Irq,
   input wire logic interblockGap,
   output logic funcReset,
   output logic abortStrobe,
   output logic [2:0] abortFunctionSelect,
   output logic cardDetectPullupOff,
   output logic contSpiIrqEnabled,
   output logic [1:0] busWidth,
   output logic interblockIrq
);
   import scc_pkg::*;

   // ----------------------------------------
   // link side: capture request, toggle across
   // ----------------------------------------
   scc_lnk_state_type lnkState_r, lnkState_nxt;
   scc_req_type lnkReq_r, lnkReq_nxt;
   logic reqTgl_r, reqTgl_nxt;
   logic ackSync1_r, ackSync2_r;
   logic irqSync1_r, irqSync2_r;
   logic hostDone_r, hostDone_nxt;
   logic [7:0] hostRdData_r, hostRdData_nxt;
   logic ackTgl_r, ackTgl_nxt;
   logic irqOut_r, irqOut_nxt;
   logic hostBusy_r, hostBusy_nxt;
   // read data is loaded on the same mclk edge that toggles its ack
   logic [7:0] rdHold_r, rdHold_nxt;

   always_comb begin
      lnkState_nxt = lnkState_r;
      lnkReq_nxt = lnkReq_r;
      reqTgl_nxt = reqTgl_r;
      hostDone_nxt = 1'b0;
      hostRdData_nxt = hostRdData_r;
      case (lnkState_r)
         LNK_IDLE: begin
            if (hostReqValid) begin
               // request word held stable until the ack returns
               lnkReq_nxt = hostReq;
               reqTgl_nxt = ~reqTgl_r;
               lnkState_nxt = LNK_WAIT;
            end
         end
         LNK_WAIT: begin
            if (ackSync2_r == reqTgl_r) begin
               hostRdData_nxt = rdHold_r;
               hostDone_nxt = 1'b1;
               lnkState_nxt = LNK_IDLE;
            end
         end
         default: lnkState_nxt = LNK_IDLE;
      endcase
      // busy from its own flop so the port never shows decode glitches
      hostBusy_nxt = (lnkState_nxt == LNK_WAIT);
   end

   always_ff @(posedge sdClk or posedge rst) begin
      if (rst) begin
         lnkState_r <= LNK_IDLE;
         lnkReq_r <= '0;
         reqTgl_r <= 1'b0;
         ackSync1_r <= 1'b0;
         ackSync2_r <= 1'b0;
         irqSync1_r <= 1'b0;
         irqSync2_r <= 1'b0;
         hostDone_r <= 1'b0;
         hostRdData_r <= 8'h00;
         hostBusy_r <= 1'b0;
      end else begin
         lnkState_r <= lnkState_nxt;
         lnkReq_r <= lnkReq_nxt;
         reqTgl_r <= reqTgl_nxt;
         ackSync1_r <= ackTgl_r;
         ackSync2_r <= ackSync1_r;
         irqSync1_r <= irqOut_r;
         irqSync2_r <= irqSync1_r;
         hostDone_r <= hostDone_nxt;
         hostRdData_r <= hostRdData_nxt;
         hostBusy_r <= hostBusy_nxt;
      end
   end

   assign hostBusy = hostBusy_r;
   assign hostDone = hostDone_r;
   assign hostRdData = hostRdData_r;
   assign irqToHost = irqSync2_r;

   // ----------------------------------------
   // core side: register bank on mclk
   // ----------------------------------------
   logic reqSync1_r, reqSync2_r;
   logic func1En_r, func1En_nxt;
   logic masterEn_r, masterEn_nxt;
   logic [2:0] abortFn_r, abortFn_nxt;
   logic abortStb_r, abortStb_nxt;
   logic funcReset_r, funcReset_nxt;
   logic pullupOff_r, pullupOff_nxt;
   logic cspiSup_r, cspiSup_nxt;
   logic cspiEn_r, cspiEn_nxt;
   logic [1:0] busWidth_r, busWidth_nxt;
   logic [7:0] cap_r, cap_nxt;
   logic [7:0] locRd_r, locRd_nxt;
   logic iblkIrq_r, iblkIrq_nxt;
   logic newReq;
   logic hostHit;
   logic [7:0] pendReg;
   logic [7:0] irqEnReg;
   logic [7:0] busReg;

   assign newReq = (reqSync2_r != ackTgl_r);
   // other function numbers are answered with zero and change nothing
   assign hostHit = newReq && (lnkReq_r.func == FN_COMMON);

   always_comb begin
      pendReg = 8'h00;
      pendReg[BIT_FUNC1_IRQ_PEND] = func1Irq;
      irqEnReg = 8'h00;
      irqEnReg[BIT_FUNC1_IRQ_EN] = func1En_r;
      irqEnReg[BIT_MASTER_IRQ_EN] = masterEn_r;
      busReg = 8'h00;
      busReg[BIT_PULLUP_OFF] = pullupOff_r;
      busReg[BIT_CSPI_SUPPORTED] = cspiSup_r;
      busReg[BIT_CSPI_ENABLED] = cspiEn_r;
      busReg[1:0] = busWidth_r;
   end

   always_comb begin
      func1En_nxt = func1En_r;
      masterEn_nxt = masterEn_r;
      abortFn_nxt = abortFn_r;
      abortStb_nxt = 1'b0;
      funcReset_nxt = 1'b0;
      pullupOff_nxt = pullupOff_r;
      cspiSup_nxt = cspiSup_r;
      cspiEn_nxt = cspiEn_r;
      busWidth_nxt = busWidth_r;
      cap_nxt = cap_r;
      ackTgl_nxt = ackTgl_r;
      rdHold_nxt = rdHold_r;
      // local writes first so a same-cycle host write to the shared bit wins
      if (locWrEn) begin
         if (locAddr == OFF_BUS_CTRL) begin
            cspiSup_nxt = locWrData[BIT_CSPI_SUPPORTED];
         end
         if (locAddr == OFF_CAPABILITY) begin
            cap_nxt = locWrData & CAP_LOCAL_MASK;
         end
      end
      if (newReq) begin
         ackTgl_nxt = reqSync2_r;
         rdHold_nxt = 8'h00;
      end
      if (hostHit && lnkReq_r.write) begin
         case (lnkReq_r.addr)
            OFF_INT_ENABLE: begin
               func1En_nxt = lnkReq_r.data[BIT_FUNC1_IRQ_EN];
               masterEn_nxt = lnkReq_r.data[BIT_MASTER_IRQ_EN];
            end
            OFF_ABORT_RESET: begin
               abortFn_nxt = lnkReq_r.data[2:0];
               abortStb_nxt = 1'b1;
               funcReset_nxt = lnkReq_r.data[BIT_CARD_RESET];
            end
            OFF_BUS_CTRL: begin
               pullupOff_nxt = lnkReq_r.data[BIT_PULLUP_OFF];
               cspiEn_nxt = lnkReq_r.data[BIT_CSPI_ENABLED];
               busWidth_nxt = lnkReq_r.data[1:0];
            end
            OFF_CAPABILITY: begin
               cap_nxt = (cap_r & ~CAP_HOST_MASK) | (lnkReq_r.data & CAP_HOST_MASK);
            end
            default: begin
            end
         endcase
      end else if (hostHit) begin
         case (lnkReq_r.addr)
            OFF_INT_ENABLE: rdHold_nxt = irqEnReg;
            OFF_INT_PENDING: rdHold_nxt = pendReg;
            OFF_BUS_CTRL: rdHold_nxt = busReg;
            OFF_CAPABILITY: rdHold_nxt = cap_r;
            default: rdHold_nxt = 8'h00;
         endcase
      end
      // card reset returns the function 1 interrupt enable and the abort select to their reset values
      if (funcReset_r) begin
         func1En_nxt = 1'b0;
         abortFn_nxt = RST_ABORT_FN;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reqSync1_r <= 1'b0;
         reqSync2_r <= 1'b0;
         ackTgl_r <= 1'b0;
         rdHold_r <= 8'h00;
         func1En_r <= 1'b0;
         masterEn_r <= 1'b0;
         abortFn_r <= RST_ABORT_FN;
         abortStb_r <= 1'b0;
         funcReset_r <= 1'b0;
         pullupOff_r <= 1'b0;
         cspiSup_r <= RST_CSPI_SUPPORTED;
         cspiEn_r <= 1'b0;
         busWidth_r <= RST_BUS_WIDTH;
         cap_r <= RST_CAPABILITY;
      end else begin
         reqSync1_r <= reqTgl_r;
         reqSync2_r <= reqSync1_r;
         ackTgl_r <= ackTgl_nxt;
         rdHold_r <= rdHold_nxt;
         func1En_r <= func1En_nxt;
         masterEn_r <= masterEn_nxt;
         abortFn_r <= abortFn_nxt;
         abortStb_r <= abortStb_nxt;
         funcReset_r <= funcReset_nxt;
         pullupOff_r <= pullupOff_nxt;
         cspiSup_r <= cspiSup_nxt;
         cspiEn_r <= cspiEn_nxt;
         busWidth_r <= busWidth_nxt;
         cap_r <= cap_nxt;
      end
   end

   // ----------------------------------------
   // local read port and interrupt forwarding
   // ----------------------------------------
   always_comb begin
      case (locAddr)
         OFF_INT_ENABLE: locRd_nxt = irqEnReg;
         OFF_INT_PENDING: locRd_nxt = pendReg;
         OFF_BUS_CTRL: locRd_nxt = busReg;
         OFF_CAPABILITY: locRd_nxt = cap_r;
         default: locRd_nxt = 8'h00;
      endcase
      // raw level only; the host side adds two flops of latency
      irqOut_nxt = func1Irq & func1En_r & masterEn_r;
      iblkIrq_nxt = interblockGap & cap_r[BIT_IBLK_CTRL] & irqOut_r;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         locRd_r <= 8'h00;
         irqOut_r <= 1'b0;
         iblkIrq_r <= 1'b0;
      end else begin
         locRd_r <= locRd_nxt;
         irqOut_r <= irqOut_nxt;
         iblkIrq_r <= iblkIrq_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign locRdData = locRd_r;
   assign funcReset = funcReset_r;
   assign abortStrobe = abortStb_r;
   assign abortFunctionSelect = abortFn_r;
   assign cardDetectPullupOff = pullupOff_r;
   assign contSpiIrqEnabled = cspiEn_r;
   assign busWidth = busWidth_r;
   assign interblockIrq = iblkIrq_r;
endmodule : scc_regs
`default_nettype wire

// ### scc_pkg.sv
// scc_pkg: constants and types for the card common control register slice
// assumes byte-wide registers in function 0 space, 17-bit register addresses
`default_nettype none
package scc_pkg;
   // ----------------------------------------
   // register offsets (function 0 space)
   // ----------------------------------------
   localparam logic [16:0] OFF_INT_ENABLE = 17'h00004;
   localparam logic [16:0] OFF_INT_PENDING = 17'h00005;
   localparam logic [16:0] OFF_ABORT_RESET = 17'h00006;
   localparam logic [16:0] OFF_BUS_CTRL = 17'h00007;
   localparam logic [16:0] OFF_CAPABILITY = 17'h00008;
   localparam logic [2:0] FN_COMMON = 3'h0;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int BIT_MASTER_IRQ_EN = 0;
   localparam int BIT_FUNC1_IRQ_EN = 1;
   localparam int BIT_FUNC1_IRQ_PEND = 1;
   localparam int BIT_CARD_RESET = 3;
   localparam int BIT_PULLUP_OFF = 7;
   localparam int BIT_CSPI_SUPPORTED = 6;
   localparam int BIT_CSPI_ENABLED = 5;
   localparam int BIT_LS_WIDE = 7;
   localparam int BIT_CARD_SPEED = 6;
   localparam int BIT_IBLK_CTRL = 5;
   localparam int BIT_IBLK_SUPPORT = 4;
   localparam int BIT_SUSPEND = 3;
   localparam int BIT_READ_WAIT = 2;
   localparam int BIT_MULTIBLOCK = 1;
   localparam int BIT_DIRECT_CMD = 0;
   // ----------------------------------------
   // reset values and encodings
   // ----------------------------------------
   localparam logic [2:0] RST_ABORT_FN = 3'h0;
   localparam logic [1:0] RST_BUS_WIDTH = 2'h0;
   localparam logic [1:0] BUS_WIDTH_1BIT = 2'h0;
   localparam logic [1:0] BUS_WIDTH_4BIT = 2'h2;
   localparam logic RST_CSPI_SUPPORTED = 1'b1;
   localparam logic [7:0] RST_CAPABILITY = 8'h3F;
   localparam logic [7:0] CAP_LOCAL_MASK = 8'hFF;
   localparam logic [7:0] CAP_HOST_MASK = 8'h20;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef struct packed {
      logic write;
      logic [2:0] func;
      logic [16:0] addr;
      logic [7:0] data;
   } scc_req_type;
   typedef enum logic {LNK_IDLE, LNK_WAIT} scc_lnk_state_type;
endpackage : scc_pkg
`default_nettype wire

// ### scc_regs_checker.sv
// checker: port timing of scc_regs
// assumes a bind from the bench top
`default_nettype none
module scc_regs_checker (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sdClk,
   input wire logic hostReqValid,
   input wire logic hostBusy,
   input wire logic hostDone,
   input wire logic [7:0] hostRdData,
   input wire logic interblockGap,
   input wire logic funcReset,
   input wire logic [2:0] abortFunctionSelect,
   input wire logic interblockIrq
);
   timeunit 1ns;
   timeprecision 1ps;
   // --------------
   // host handshake
   // --------------
   sequence sTake;
      hostReqValid && !hostBusy;
   endsequence
   sequence sServe;
      hostBusy ##[1:12] hostDone;
   endsequence
   chk_take_serve: assert property (@(posedge sdClk) disable iff (rst) sTake |=> sServe)
      else $error("request not served");
   chk_done_pulse: assert property (@(posedge sdClk) disable iff (rst) hostDone |=> !hostDone)
      else $error("done longer than one cycle");
   chk_done_idle: assert property (@(posedge sdClk) disable iff (rst) hostDone |-> !hostBusy)
      else $error("busy at done");
   chk_busy_cause: assert property (@(posedge sdClk) disable iff (rst) $rose(hostBusy) |-> $past(hostReqValid))
      else $error("busy without request");
   chk_rdata_hold: assert property (@(posedge sdClk) disable iff (rst) $changed(hostRdData) |-> hostDone)
      else $error("read data moved without done");
   // ------------------
   // core side effects
   // ------------------
   chk_reset_pulse: assert property (@(posedge mclk) disable iff (rst) funcReset |=> !funcReset)
      else $error("card reset not self clearing");
   chk_reset_abort: assert property (@(posedge mclk) disable iff (rst) funcReset |-> ##[1:2] abortFunctionSelect == 3'h0)
      else $error("abort field kept over card reset");
   chk_iblk_gap: assert property (@(posedge mclk) disable iff (rst) interblockIrq |-> $past(interblockGap))
      else $error("inter-block irq outside gap");
endmodule // scc_regs_checker
`default_nettype wire

// ### scc_host_model.sv
// host model: single-byte requests on the link side
// assumes one caller at a time, link clock from the bench
`default_nettype none
module scc_host_model
   import scc_pkg::*;
(
   input wire logic sdClk,
   input wire logic hostBusy,
   input wire logic hostDone,
   input wire logic [7:0] hostRdData,
   output logic hostReqValid,
   output scc_pkg::scc_req_type hostReq,
   output logic timedOut
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hostReqValid = 1'b0;
      hostReq = '0;
      timedOut = 1'b0;
   end
   // callers only write widths 0 or 2
   task automatic xfer(input logic w, input logic [2:0] f, input logic [16:0] a, input logic [7:0] d,
         output logic [7:0] q);
      int n;
      logic idle;
      n = 0;
      idle = 1'b0;
      @(posedge sdClk);
      hostReqValid <= 1'b1;
      hostReq <= '{w, f, a, d};
      // busy is settled at the falling edge; idle there means taken at the next rise
      do begin
         @(negedge sdClk);
         idle = !hostBusy;
         @(posedge sdClk);
         n++;
      end while (!idle && n < 20);
      hostReqValid <= 1'b0;
      // released lines scrambled so stale values never pass
      hostReq <= scc_req_type'(~hostReq);
      do begin
         @(negedge sdClk);
         n++;
      end while (!hostDone && n < 40);
      q = hostRdData;
      if (n >= 40) timedOut = 1'b1;
   endtask
endmodule // scc_host_model
`default_nettype wire

// ### scc_tb.sv
// tb: host and local accesses to the register slice
// assumes scc_pkg, scc_regs, checker and host model compiled first
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import scc_pkg::*;
   logic mclk = 1'b0, sdClk = 1'b0, rst = 1'b1, locWrEn = 1'b0, func1Irq = 1'b0, interblockGap = 1'b0;
   logic [16:0] locAddr = '0;
   logic [7:0] locWrData = '0, locRdData, hostRdData, rd;
   logic hostReqValid, hostBusy, hostDone, irqToHost, funcReset, abortStrobe, timedOut, sawReset = 1'b0;
   logic sawStrobe = 1'b0;
   logic cardDetectPullupOff, contSpiIrqEnabled, interblockIrq;
   logic [2:0] abortFunctionSelect;
   logic [1:0] busWidth;
   scc_req_type hostReq;
   int failures = 0, compares = 0;
   scc_regs dut (
      .mclk(mclk), .rst(rst), .sdClk(sdClk), .hostReqValid(hostReqValid), .hostReq(hostReq),
      .hostBusy(hostBusy), .hostDone(hostDone), .hostRdData(hostRdData), .irqToHost(irqToHost),
      .locWrEn(locWrEn), .locAddr(locAddr), .locWrData(locWrData), .locRdData(locRdData),
      .func1Irq(func1Irq), .interblockGap(interblockGap), .funcReset(funcReset), .abortStrobe(abortStrobe),
      .abortFunctionSelect(abortFunctionSelect), .cardDetectPullupOff(cardDetectPullupOff),
      .contSpiIrqEnabled(contSpiIrqEnabled), .busWidth(busWidth), .interblockIrq(interblockIrq)
   );
   scc_host_model host (
      .sdClk(sdClk), .hostBusy(hostBusy), .hostDone(hostDone), .hostRdData(hostRdData),
      .hostReqValid(hostReqValid), .hostReq(hostReq), .timedOut(timedOut)
   );
   always #2.5 mclk = ~mclk;
   always #15 sdClk = ~sdClk;
   always @(posedge mclk) if (funcReset) sawReset <= 1'b1;
   always @(posedge mclk) if (abortStrobe) sawStrobe <= 1'b1;
   // -----------
   // access tasks
   // -----------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hw(input logic [16:0] a, input logic [7:0] d);
      host.xfer(1'b1, FN_COMMON, a, d, rd);
   endtask
   task automatic hr(input logic [16:0] a, input logic [7:0] e);
      host.xfer(1'b0, FN_COMMON, a, 8'h00, rd);
      check(rd, e);
   endtask
   task automatic lw(input logic [16:0] a, input logic [7:0] d);
      @(posedge mclk);
      locWrEn <= 1'b1;
      locAddr <= a;
      locWrData <= d;
      @(posedge mclk);
      locWrEn <= 1'b0;
   endtask
   task automatic lr(input logic [16:0] a, input logic [7:0] e);
      @(posedge mclk);
      locAddr <= a;
      repeat (2) @(posedge mclk);
      #1 check(locRdData, e);
   endtask
   // irq crosses two flops, so allow a bounded wait
   task automatic waitIrq(input logic e);
      int n;
      n = 0;
      while (irqToHost !== e && n < 40) begin
         @(negedge sdClk);
         n++;
      end
      check({7'h00, irqToHost}, {7'h00, e});
   endtask
   task automatic results;
      if (timedOut) failures++;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // --------
   // sequence
   // --------
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      hr(OFF_INT_ENABLE, 8'h00);
      hr(OFF_INT_PENDING, 8'h00);
      hr(OFF_ABORT_RESET, 8'h00);
      hr(OFF_BUS_CTRL, 8'h40);
      hr(OFF_CAPABILITY, 8'h3F);
      @(posedge mclk) func1Irq <= 1'b1;
      hw(OFF_INT_ENABLE, 8'hFF);
      hr(OFF_INT_ENABLE, 8'h03);
      waitIrq(1'b1);
      hr(OFF_INT_PENDING, 8'h02);
      hw(OFF_INT_ENABLE, 8'h02);
      waitIrq(1'b0);
      hw(OFF_INT_ENABLE, 8'h01);
      waitIrq(1'b0);
      hw(OFF_INT_ENABLE, 8'h03);
      @(posedge mclk) interblockGap <= 1'b1;
      repeat (8) @(posedge mclk);
      #1 check({7'h00, interblockIrq}, 8'h01);
      lw(OFF_CAPABILITY, 8'h1F);
      repeat (3) @(posedge mclk);
      #1 check({7'h00, interblockIrq}, 8'h00);
      hw(OFF_CAPABILITY, 8'hC0);
      hr(OFF_CAPABILITY, 8'h1F);
      hw(OFF_CAPABILITY, 8'h20);
      hr(OFF_CAPABILITY, 8'h3F);
      lw(OFF_CAPABILITY, 8'hC0);
      lr(OFF_CAPABILITY, 8'hC0);
      hr(OFF_CAPABILITY, 8'hC0);
      hw(OFF_BUS_CTRL, 8'hA2);
      hr(OFF_BUS_CTRL, 8'hE2);
      check({4'h0, cardDetectPullupOff, contSpiIrqEnabled, busWidth}, 8'h0E);
      lw(OFF_BUS_CTRL, 8'h00);
      lr(OFF_BUS_CTRL, 8'hA2);
      hw(OFF_BUS_CTRL, 8'h00);
      hr(OFF_BUS_CTRL, 8'h00);
      hw(OFF_ABORT_RESET, 8'h05);
      check({5'h00, abortFunctionSelect}, 8'h05);
      check({6'h00, sawStrobe, sawReset}, 8'h02);
      hr(OFF_ABORT_RESET, 8'h00);
      hw(OFF_ABORT_RESET, 8'h0D);
      check({7'h00, sawReset}, 8'h01);
      check({5'h00, abortFunctionSelect}, 8'h00);
      hr(OFF_INT_ENABLE, 8'h01);
      host.xfer(1'b1, 3'h1, OFF_INT_ENABLE, 8'h02, rd);
      hr(OFF_INT_ENABLE, 8'h01);
      host.xfer(1'b0, 3'h1, OFF_INT_ENABLE, 8'h00, rd);
      check(rd, 8'h00);
      hr(17'h00009, 8'h00);
      results;
   end
endmodule // tb
bind scc_regs scc_regs_checker chk (
   .mclk(mclk), .rst(rst), .sdClk(sdClk), .hostReqValid(hostReqValid), .hostBusy(hostBusy),
   .hostDone(hostDone), .hostRdData(hostRdData), .interblockGap(interblockGap), .funcReset(funcReset),
   .abortFunctionSelect(abortFunctionSelect), .interblockIrq(interblockIrq)
);
`default_nettype wire
